// ### core/ceas_defs.vh
// Constants of the communication error action and status parameter bank.
// Assumes parameter numbers arrive as plain binary on the access port.
`ifndef CEAS_DEFS_VH
`define CEAS_DEFS_VH

// Parameter numbers used as register indices
`define CEAS_IDX_ACTION_SEL    10'h139
`define CEAS_IDX_STATUS_WORD   10'h2a8
`define CEAS_IDX_CTRL_WORD     10'h2ae

// Reset values
`define CEAS_ACTION_RESET      3'h0
`define CEAS_CTRL_RESET        16'h0000

// Error action codes
`define CEAS_ACT_OFF           3'h0
`define CEAS_ACT_RAMP_STOP     3'h1
`define CEAS_ACT_GEN_DISABLE   3'h2
`define CEAS_ACT_GO_LOCAL      3'h3
`define CEAS_ACT_OFF_ALT       3'h4
`define CEAS_ACT_FAULT         3'h5

// Control word fields
`define CEAS_CW_START          0
`define CEAS_CW_ENABLE         1
`define CEAS_CW_JOG            2
`define CEAS_CW_REVERSE        3
`define CEAS_CW_REMOTE         4
`define CEAS_CW_FAULT_RESET    7
`define CEAS_CW_USED_MASK      16'h009f

// Status word fields
`define CEAS_SW_RUNNING        0
`define CEAS_SW_ENABLED        1
`define CEAS_SW_JOG            2
`define CEAS_SW_ACCEL          3
`define CEAS_SW_POST_STOP      4
`define CEAS_SW_FULL_VOLT      5
`define CEAS_SW_ALARM          6
`define CEAS_SW_DECEL          7
`define CEAS_SW_REMOTE         8
`define CEAS_SW_BRAKING        9
`define CEAS_SW_REVERSING      10
`define CEAS_SW_REVERSE        11
`define CEAS_SW_BYPASS         12
`define CEAS_SW_CONFIG         13
`define CEAS_SW_MAINS          14
`define CEAS_SW_FAULT          15

`endif

// ### core/ceas_top.v
// Communication error action and drive status word parameter bank.
// Assumes all drive state inputs and the access port run on clock_i.
//
// How it works
// - Settings 0 and 4 leave the drive untouched on a communication error.
// - Setting 1 clears the start bit, giving a ramp stop.
// - Setting 2 clears the general enable bit, motor coasts.
// - Setting 3 clears the remote bit, sending commands to local.
// - Setting 5 latches a fault instead of alarm until fault reset.
// - Module offline and module access error are separate error codes.
// - Action writes control word bits, only when network is command source.
// - Status word is a read-only 16-bit reflection of drive state.
// - Bit 0 running; bit 1 set only when all enable sources agree.
// - Bit 2 jog active; bit 3 whole acceleration phase.
// - Bit 4 post-stop interval elapsing; bit 5 full voltage applied.
// - Bit 6 any alarm active; bit 7 throughout deceleration.
// - Bit 8 remote versus local; bit 9 braking.
// - Bit 10 reversal in progress; bit 11 reverse rotation.
// - Bit 13 configuration mode, during which enabling is refused.
// - Bit 14 set only when all three mains phases are present.
// - Bit 15 set whenever any fault has been detected.
// - Control word is 16 bits and resets to zero.
// - Control bits: 0 start, 1 enable, 4 remote, 7 fault reset.
// - Only the fieldbus source may write the control word.
`timescale 1ns/1ps
`include "ceas_defs.vh"

module ceas_top (
    input  wire        clock_i,
    input  wire        resetn_i,
    // Parameter access port
    input  wire        acc_req_i,
    input  wire        acc_write_i,
    input  wire        acc_from_fieldbus_i,
    input  wire [9:0]  acc_index_i,
    input  wire [15:0] acc_wdata_i,
    output reg         acc_ack_o,
    output reg         acc_err_o,
    output reg  [15:0] acc_rdata_o,
    // Communication module condition
    input  wire        module_offline_i,
    input  wire        module_access_err_i,
    input  wire        network_is_cmd_source_i,
    // Drive state
    input  wire        motor_running_i,
    input  wire [3:0]  enable_sources_i,
    input  wire        jog_active_i,
    input  wire        accelerating_i,
    input  wire        post_stop_interval_i,
    input  wire        full_voltage_i,
    input  wire        drive_alarm_i,
    input  wire        decelerating_i,
    input  wire        remote_mode_i,
    input  wire        braking_i,
    input  wire        reversing_i,
    input  wire        reverse_rotation_i,
    input  wire        bypass_closed_i,
    input  wire        config_mode_i,
    input  wire [2:0]  mains_phase_ok_i,
    input  wire        drive_fault_i,
    // Results
    output reg  [15:0] network_control_word_o,
    output reg  [15:0] drive_status_word_o,
    output reg  [2:0]  comm_error_action_select_o,
    output reg         general_enable_o,
    output reg         module_offline_alarm_o,
    output reg         module_access_alarm_o,
    output reg         module_offline_fault_o,
    output reg         module_access_fault_o
);

    reg  [1:0]  rst_sync_q;
    wire        rst_n;

    reg  [2:0]  action_q;
    reg  [2:0]  action_d;
    reg  [15:0] ctrl_q;
    reg  [15:0] ctrl_d;
    reg         offline_q;
    reg         access_q;
    reg         off_fault_q;
    reg         off_fault_d;
    reg         acc_fault_q;
    reg         acc_fault_d;
    reg  [15:0] status_d;
    reg         ack_d;
    reg         err_d;
    reg  [15:0] rdata_d;

    wire        off_rise;
    wire        acc_rise;
    wire        err_rise;
    wire        fault_mode;
    wire        ctrl_wr;
    wire        sel_wr;
    wire        fault_reset_req;
    wire [1:0]  acc_region;

    // Register regions of the parameter index
    localparam [1:0] REG_NONE   = 2'b00;
    localparam [1:0] REG_ACTION = 2'b01;
    localparam [1:0] REG_STATUS = 2'b10;
    localparam [1:0] REG_CTRL   = 2'b11;

    // Index decode shared by the write strobes and the read answer
    function [1:0] region_of;
        input [9:0] index;
        begin
            if (index == `CEAS_IDX_ACTION_SEL) begin
                region_of = REG_ACTION;
            end else if (index == `CEAS_IDX_STATUS_WORD) begin
                region_of = REG_STATUS;
            end else if (index == `CEAS_IDX_CTRL_WORD) begin
                region_of = REG_CTRL;
            end else begin
                region_of = REG_NONE;
            end
        end
    endfunction

    assign acc_region = region_of(acc_index_i);

    // Reset release through two flip-flops
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign off_rise   = module_offline_i & ~offline_q;
    assign acc_rise   = module_access_err_i & ~access_q;
    assign err_rise   = off_rise | acc_rise;
    assign fault_mode = (action_q == `CEAS_ACT_FAULT);

    // control word writes only from fieldbus
    assign ctrl_wr = acc_req_i & acc_write_i & acc_from_fieldbus_i
                     & (acc_region == REG_CTRL);
    // Action setting may change only with the motor stopped
    assign sel_wr  = acc_req_i & acc_write_i & ~motor_running_i
                     & (acc_region == REG_ACTION)
                     & (acc_wdata_i[15:3] == 13'h0000)
                     & (acc_wdata_i[2:0] <= `CEAS_ACT_FAULT);
    assign fault_reset_req = ctrl_wr & acc_wdata_i[`CEAS_CW_FAULT_RESET];

    always @* begin
        action_d = action_q;
        if (sel_wr) begin
            action_d = acc_wdata_i[2:0];
        end
    end

    always @* begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = acc_wdata_i;
        end
        // action only under network command source
        if (err_rise && network_is_cmd_source_i) begin
            case (action_q)
                `CEAS_ACT_RAMP_STOP: begin
                    ctrl_d[`CEAS_CW_START] = 1'b0;
                end
                `CEAS_ACT_GEN_DISABLE: begin
                    ctrl_d[`CEAS_CW_ENABLE] = 1'b0;
                end
                `CEAS_ACT_GO_LOCAL: begin
                    ctrl_d[`CEAS_CW_REMOTE] = 1'b0;
                end
                // settings 0 and 4 keep the present state
                `CEAS_ACT_OFF, `CEAS_ACT_OFF_ALT: begin
                    ctrl_d = ctrl_d;
                end
                // fault mode latches a fault, word untouched
                `CEAS_ACT_FAULT: begin
                    ctrl_d = ctrl_d;
                end
                default: begin
                    ctrl_d = ctrl_d;
                end
            endcase
        end
    end

    // latched faults; a new error beats a same-cycle reset
    always @* begin
        off_fault_d = off_fault_q;
        acc_fault_d = acc_fault_q;
        if (fault_reset_req) begin
            off_fault_d = 1'b0;
            acc_fault_d = 1'b0;
        end
        if (fault_mode && module_offline_i && (off_rise || !fault_reset_req)) begin
            off_fault_d = off_fault_d | off_rise;
        end
        if (fault_mode && module_access_err_i && (acc_rise || !fault_reset_req)) begin
            acc_fault_d = acc_fault_d | acc_rise;
        end
    end

    always @* begin
        status_d = 16'h0000;
        status_d[`CEAS_SW_RUNNING]   = motor_running_i;
        status_d[`CEAS_SW_ENABLED]   = (&enable_sources_i) & ~config_mode_i;
        status_d[`CEAS_SW_JOG]       = jog_active_i;
        status_d[`CEAS_SW_ACCEL]     = accelerating_i;
        status_d[`CEAS_SW_POST_STOP] = post_stop_interval_i;
        status_d[`CEAS_SW_FULL_VOLT] = full_voltage_i;
        status_d[`CEAS_SW_ALARM]     = drive_alarm_i
                                       | (~fault_mode & (module_offline_i | module_access_err_i));
        status_d[`CEAS_SW_DECEL]     = decelerating_i;
        status_d[`CEAS_SW_REMOTE]    = remote_mode_i;
        status_d[`CEAS_SW_BRAKING]   = braking_i;
        status_d[`CEAS_SW_REVERSING] = reversing_i;
        status_d[`CEAS_SW_REVERSE]   = reverse_rotation_i;
        status_d[`CEAS_SW_BYPASS]    = bypass_closed_i;
        status_d[`CEAS_SW_CONFIG]    = config_mode_i;
        status_d[`CEAS_SW_MAINS]     = &mains_phase_ok_i;
        status_d[`CEAS_SW_FAULT]     = drive_fault_i | off_fault_q | acc_fault_q;
    end

    // Access answer: one cycle after the request
    always @* begin
        ack_d   = acc_req_i;
        err_d   = 1'b0;
        rdata_d = 16'h0000;
        if (acc_req_i) begin
            if (acc_region == REG_ACTION) begin
                rdata_d = {13'h0000, action_q};
                err_d   = acc_write_i & ~sel_wr;
            end else if (acc_region == REG_STATUS) begin
                // writes refused
                // Read data is the registered copy, one cycle behind the pins
                rdata_d = drive_status_word_o;
                err_d   = acc_write_i;
            end else if (acc_region == REG_CTRL) begin
                rdata_d = ctrl_q;
                err_d   = acc_write_i & ~acc_from_fieldbus_i;
            end else begin
                err_d   = 1'b1;
            end
        end
    end

    // Setting and control word; outputs copy the next value so they match the registers
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            action_q                   <= `CEAS_ACTION_RESET;
            comm_error_action_select_o <= `CEAS_ACTION_RESET;
            ctrl_q                     <= `CEAS_CTRL_RESET;
            network_control_word_o     <= `CEAS_CTRL_RESET;
            general_enable_o           <= 1'b0;
        end else begin
            action_q                   <= action_d;
            comm_error_action_select_o <= action_d;
            ctrl_q                     <= ctrl_d;
            network_control_word_o     <= ctrl_d;
            general_enable_o           <= ctrl_d[`CEAS_CW_ENABLE] & ~config_mode_i;
        end
    end

    // previous error levels for the edge detectors
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            offline_q <= 1'b0;
            access_q  <= 1'b0;
        end else begin
            offline_q <= module_offline_i;
            access_q  <= module_access_err_i;
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            off_fault_q            <= 1'b0;
            acc_fault_q            <= 1'b0;
            module_offline_fault_o <= 1'b0;
            module_access_fault_o  <= 1'b0;
        end else begin
            off_fault_q            <= off_fault_d;
            acc_fault_q            <= acc_fault_d;
            module_offline_fault_o <= off_fault_d;
            module_access_fault_o  <= acc_fault_d;
        end
    end

    // separate alarm per error kind, silenced in fault mode
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            module_offline_alarm_o <= 1'b0;
            module_access_alarm_o  <= 1'b0;
        end else begin
            module_offline_alarm_o <= module_offline_i & ~fault_mode;
            module_access_alarm_o  <= module_access_err_i & ~fault_mode;
        end
    end

    // Access answer, standing for one cycle
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_ack_o   <= 1'b0;
            acc_err_o   <= 1'b0;
            acc_rdata_o <= 16'h0000;
        end else begin
            acc_ack_o   <= ack_d;
            acc_err_o   <= err_d;
            acc_rdata_o <= rdata_d;
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            drive_status_word_o <= 16'h0000;
        end else begin
            drive_status_word_o <= status_d;
        end
    end

endmodule // ceas_top

// ### dv/ceas_top_assertions.sv
// Concurrent checks on the error action and status bank ports.
// Assumes one clock; bound into every ceas_top instance below.
`timescale 1ns/1ps
`include "ceas_defs.vh"
module ceas_chk (
    input wire        clock_i,
    input wire        resetn_i,
    input wire        acc_req_i,
    input wire        acc_write_i,
    input wire        acc_from_fieldbus_i,
    input wire [9:0]  acc_index_i,
    input wire [15:0] acc_wdata_i,
    input wire        acc_err_o,
    input wire        module_offline_i,
    input wire        module_access_err_i,
    input wire        network_is_cmd_source_i,
    input wire        config_mode_i,
    input wire [15:0] network_control_word_o,
    input wire [15:0] drive_status_word_o,
    input wire [2:0]  comm_error_action_select_o,
    input wire        general_enable_o,
    input wire        module_offline_alarm_o,
    input wire        module_access_fault_o
);
    reg [1:0] live_q;
    // Outputs follow inputs only once the internal reset copy has lifted
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i)
            live_q <= 2'h0;
        else if (live_q != 2'h3)
            live_q <= live_q + 2'h1;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i || live_q != 2'h3);
    sequence s_calm;
        !module_offline_i && !module_access_err_i;
    endsequence
    sequence s_ctrl_wr;
        acc_req_i && acc_write_i && acc_index_i == `CEAS_IDX_CTRL_WORD;
    endsequence
    property p_ctrl_write;
        s_ctrl_wr ##0 s_calm ##0 acc_from_fieldbus_i
            |=> !acc_err_o && network_control_word_o == $past(acc_wdata_i);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
    property p_ctrl_ro;
        s_ctrl_wr ##0 s_calm ##0 !acc_from_fieldbus_i |=> acc_err_o && $stable(network_control_word_o);
    endproperty
    a_ctrl_ro: assert property (p_ctrl_ro) else $error("control word not guarded");
    property p_status_ro;
        acc_req_i && acc_write_i && acc_index_i == `CEAS_IDX_STATUS_WORD |=> acc_err_o;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write accepted");
    property p_ramp_stop;
        $rose(module_access_err_i) && !module_offline_i && network_is_cmd_source_i
            && comm_error_action_select_o == 3'h1 |=> !network_control_word_o[0];
    endproperty
    a_ramp_stop: assert property (p_ramp_stop) else $error("start bit kept");
    property p_gen_disable;
        $rose(module_offline_i) && !module_access_err_i && network_is_cmd_source_i
            && comm_error_action_select_o == 3'h2 |=> !network_control_word_o[1];
    endproperty
    a_gen_disable: assert property (p_gen_disable) else $error("enable bit kept");
    property p_fault;
        $rose(module_access_err_i) && !module_offline_i && network_is_cmd_source_i
            && comm_error_action_select_o == 3'h5 |=> module_access_fault_o;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not latched");
    property p_alarm;
        comm_error_action_select_o != 3'h5 |=> module_offline_alarm_o == $past(module_offline_i);
    endproperty
    a_alarm: assert property (p_alarm) else $error("offline alarm wrong");
    property p_config;
        config_mode_i |=> !general_enable_o && drive_status_word_o[13];
    endproperty
    a_config: assert property (p_config) else $error("enabled in config mode");
    property p_once;
        !acc_req_i && !$rose(module_offline_i) && !$rose(module_access_err_i)
            |=> $stable(network_control_word_o);
    endproperty
    a_once: assert property (p_once) else $error("control word moved alone");
endmodule // ceas_chk

bind ceas_top ceas_chk u_chk (
    .clock_i(clock_i), .resetn_i(resetn_i), .acc_req_i(acc_req_i), .acc_write_i(acc_write_i),
    .acc_from_fieldbus_i(acc_from_fieldbus_i), .acc_index_i(acc_index_i),
    .acc_wdata_i(acc_wdata_i), .acc_err_o(acc_err_o), .module_offline_i(module_offline_i),
    .module_access_err_i(module_access_err_i), .config_mode_i(config_mode_i),
    .network_is_cmd_source_i(network_is_cmd_source_i),
    .network_control_word_o(network_control_word_o), .drive_status_word_o(drive_status_word_o),
    .comm_error_action_select_o(comm_error_action_select_o), .general_enable_o(general_enable_o),
    .module_offline_alarm_o(module_offline_alarm_o), .module_access_fault_o(module_access_fault_o)
);

// ### dv/ceas_fb_master.sv
// Fieldbus master model issuing one parameter word access at a time.
// Assumes the bank answers one clock after the request edge.
`timescale 1ns/1ps
module ceas_fb_master (
    input  wire         clock_i,
    input  wire         acc_ack_i,
    input  wire         acc_err_i,
    input  wire  [15:0] acc_rdata_i,
    output wire         acc_req_o,
    output wire         acc_write_o,
    output wire         acc_from_fieldbus_o,
    output wire  [9:0]  acc_index_o,
    output wire  [15:0] acc_wdata_o
);
    logic [28:0] bus = 29'h0;
    assign {acc_req_o, acc_write_o, acc_from_fieldbus_o, acc_index_o, acc_wdata_o} = bus;
    // Idle gap, request held over one edge; released lines show inverted values
    task automatic xfer(input logic w, fb, input logic [9:0] idx, input logic [15:0] wd,
                        input int gap, output logic [15:0] rd, output logic er, ak);
        repeat (gap + 1) @(negedge clock_i);
        bus = {1'b1, w, fb, idx, wd};
        @(negedge clock_i);
        {rd, er, ak} = {acc_rdata_i, acc_err_i, acc_ack_i};
        bus = {1'b0, ~w, ~fb, ~idx, ~wd};
    endtask
endmodule // ceas_fb_master

// ### dv/ceas_top_bench.sv
// Self-checking bench for the error action and status bank.
// Assumes the master model and the checker are compiled alongside.
`timescale 1ns/1ps
`include "ceas_defs.vh"
module ceas_top_bench;
    logic        clock_i = 1'b0, resetn_i = 1'b0, acc_req_i, acc_write_i, acc_from_fieldbus_i;
    logic        acc_ack_o, acc_err_o, er, ak, general_enable_o, module_offline_alarm_o;
    logic        module_access_alarm_o, module_offline_fault_o, module_access_fault_o;
    logic        module_offline_i = 1'b0, module_access_err_i = 1'b0;
    logic        network_is_cmd_source_i = 1'b1, config_mode_i, drive_fault_i, motor_running_i;
    logic        jog_active_i, accelerating_i, post_stop_interval_i, full_voltage_i;
    logic        drive_alarm_i, decelerating_i, remote_mode_i, braking_i, reversing_i;
    logic        reverse_rotation_i, bypass_closed_i;
    logic [9:0]  acc_index_i;
    logic [15:0] acc_wdata_i, acc_rdata_o, network_control_word_o, drive_status_word_o;
    logic [15:0] rd, v, ctrl = 16'h0, sel = 16'h0;
    logic [2:0]  comm_error_action_select_o, mains_phase_ok_i;
    logic [3:0]  enable_sources_i;
    logic [20:0] st = 21'h0;
    logic [1:0]  alm = 2'h0, flt = 2'h0;
    int          fails = 0, n_tests = 0, cyc = 0;
    assign {drive_fault_i, mains_phase_ok_i, config_mode_i, bypass_closed_i, reverse_rotation_i,
            reversing_i, braking_i, remote_mode_i, decelerating_i, drive_alarm_i, full_voltage_i,
            post_stop_interval_i, accelerating_i, jog_active_i, enable_sources_i,
            motor_running_i} = st;
    always #2.5 clock_i = ~clock_i;
    ceas_top dut (.*);
    ceas_fb_master u_fb (.clock_i(clock_i), .acc_ack_i(acc_ack_o), .acc_err_i(acc_err_o),
        .acc_rdata_i(acc_rdata_o), .acc_req_o(acc_req_i), .acc_write_o(acc_write_i),
        .acc_from_fieldbus_o(acc_from_fieldbus_i), .acc_index_o(acc_index_i),
        .acc_wdata_o(acc_wdata_i));
    function automatic logic [15:0] sw_exp();
        return {drive_fault_i | (|flt), &mains_phase_ok_i, config_mode_i, bypass_closed_i,
                reverse_rotation_i, reversing_i, braking_i, remote_mode_i, decelerating_i,
                drive_alarm_i | (|alm), full_voltage_i, post_stop_interval_i, accelerating_i,
                jog_active_i, &enable_sources_i & ~config_mode_i, motor_running_i};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, fb, input logic [9:0] idx, input logic [15:0] wd,
                       input logic e, input logic [15:0] rexp);
        u_fb.xfer(w, fb, idx, wd, $urandom_range(2, 0), rd, er, ak);
        chk({14'h0, ak, er}, {14'h0, 1'b1, e});
        if (!e)
            chk(rd, rexp);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h554c23a2));
        repeat (5) @(negedge clock_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clock_i);
        acc(0, 1, `CEAS_IDX_CTRL_WORD, 16'h0, 0, 16'h0);
        acc(0, 0, `CEAS_IDX_ACTION_SEL, 16'h0, 0, 16'h0);
        acc(1, 0, `CEAS_IDX_CTRL_WORD, 16'hffff, 1, 16'h0);
        acc(1, 1, `CEAS_IDX_STATUS_WORD, 16'h5a5a, 1, 16'h0);
        acc(0, 1, 10'h3ff, 16'h0, 1, 16'h0);
        st[0] = 1'b1;
        acc(1, 1, `CEAS_IDX_ACTION_SEL, 16'h2, 1, 16'h0);
        st[0] = 1'b0;
        acc(1, 1, `CEAS_IDX_ACTION_SEL, 16'h6, 1, 16'h0);
        chk({13'h0, comm_error_action_select_o}, sel);
        chk(network_control_word_o, ctrl);
        for (int i = 0; i < 16; i++) begin
            st = 21'($urandom);
            v = 16'($urandom);
            acc(1, 1, `CEAS_IDX_CTRL_WORD, v, 0, ctrl);
            ctrl = v;
            chk(network_control_word_o, ctrl);
            chk({15'h0, general_enable_o}, {15'h0, ctrl[1] & ~config_mode_i});
            chk(drive_status_word_o, sw_exp());
        end
        st = 21'h0;
        for (int a = 0; a < 7; a++) begin
            v = (a == 6) ? 16'h1 : 16'(a);
            acc(1, 1, `CEAS_IDX_ACTION_SEL, v, 0, sel);
            sel = v;
            acc(1, 1, `CEAS_IDX_CTRL_WORD, 16'h0013, 0, ctrl);
            ctrl = 16'h0013;
            network_is_cmd_source_i = (a != 6);
            @(negedge clock_i);
            if (a % 2)
                module_access_err_i = 1'b1;
            else
                module_offline_i = 1'b1;
            alm = (v == 16'h5) ? 2'h0 : ((a % 2) ? 2'h2 : 2'h1);
            flt = (v == 16'h5) ? 2'h2 : 2'h0;
            if (a > 0 && a < 4)
                ctrl[(a == 3) ? 4 : a - 1] = 1'b0;
            @(negedge clock_i);
            chk(network_control_word_o, ctrl);
            chk({12'h0, module_access_alarm_o, module_offline_alarm_o, module_access_fault_o,
                 module_offline_fault_o}, {12'h0, alm, flt});
            acc(1, 1, `CEAS_IDX_CTRL_WORD, 16'h0013, 0, ctrl);
            ctrl = 16'h0013;
            @(negedge clock_i);
            chk(network_control_word_o, ctrl);
            chk(drive_status_word_o, sw_exp());
            {module_offline_i, module_access_err_i} = 2'h0;
            alm = 2'h0;
            repeat (2) @(negedge clock_i);
            chk({14'h0, module_access_fault_o, module_offline_fault_o}, {14'h0, flt});
            acc(1, 1, `CEAS_IDX_CTRL_WORD, 16'h0080, 0, ctrl);
            ctrl = 16'h0080;
            flt = 2'h0;
            chk({14'h0, module_access_fault_o, module_offline_fault_o}, 16'h0);
        end
        print_verdict();
    end
endmodule // ceas_top_bench
